// ### logic/bct_map.svh
/*
  Register offsets, field positions, reset values and sizes of the bus-cycle
  trace capture unit. Assumes inclusion by bare name from design files.
*/
`ifndef BCT_MAP_SVH
`define BCT_MAP_SVH

`define BCT_OFS_CTRL      12'h000
`define BCT_OFS_STATUS    12'h004
`define BCT_OFS_TRIG_POS  12'h008
`define BCT_OFS_WR_PTR    12'h00C
`define BCT_OFS_RD_ADDR   12'h010
`define BCT_OFS_RD_DATA   12'h014
`define BCT_OFS_RANGE_LO  12'h018
`define BCT_OFS_RANGE_HI  12'h01C
`define BCT_OFS_TRIG_BASE 12'h020

`define BCT_NUM_TRIG      4
`define BCT_DEPTH         8192
`define BCT_HALF          4096
`define BCT_AW            13

`define BCT_CTRL_ARM      0
`define BCT_CTRL_RANGE_EN 1
`define BCT_CTRL_MODE_LSB 2
`define BCT_CTRL_TYPE_LSB 3

`define BCT_ST_ARMED      0
`define BCT_ST_RUNNING    1
`define BCT_ST_TRIGGERED  2
`define BCT_ST_FULL       3
`define BCT_ST_EMPTY      4
`define BCT_ST_WRAPPED    5

`define BCT_AUX_MARK      6
`define BCT_AUX_RW        7

`define BCT_TRIG_RST      16'hFFFF
`define BCT_CTRL_RST      4'h0

`endif

// ### logic/bct_pkg.sv
/*
  Types of the bus-cycle trace capture unit.
  Assumes bct_map.svh supplies the numeric constants.
*/
package bct_pkg;

  typedef enum logic {BCT_MODE_EXEC, BCT_MODE_SELECT} bct_mode_t;

  typedef enum logic [1:0] {BCT_TYPE_AFTER, BCT_TYPE_BEFORE, BCT_TYPE_ABOUT} bct_type_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
    logic        first;
    logic [5:0]  tp;
  } bct_cycle_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  aux;
  } bct_entry_t;

endpackage : bct_pkg

// ### logic/bct_mem.sv
/*
  Capture memory: 8K words of 32 bits, one write port, one read port.
  Assumes one clock; read data come out of a register one cycle later.
*/
module bct_mem
  import bct_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        we,
  input  wire logic [12:0] waddr,
  input  wire bct_entry_t  wdata,
  input  wire logic [12:0] raddr,
  output bct_entry_t       rdata
);

  bct_entry_t mem [0:8191];

  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : bct_mem

// ### logic/bct_match.sv
/*
  Trigger comparator: several independent addresses plus one inclusive range.
  Assumes the host keeps addresses in the allowed span and hi above lo.
*/
`include "bct_map.svh"

module bct_match
  import bct_pkg::*;
(
  input  wire logic [15:0]          addr,
  input  wire logic [4*16-1:0]      trig_addr,
  input  wire logic                 range_en,
  input  wire logic [15:0]          range_lo,
  input  wire logic [15:0]          range_hi,
  output logic                      hit
);

  logic [`BCT_NUM_TRIG-1:0] single_hit;

  genvar i;
  generate
    for (i = 0; i < `BCT_NUM_TRIG; i++)
    begin : g_cmp
      assign single_hit[i] = (trig_addr[i*16 +: 16] == addr);
    end
  endgenerate

  assign hit = (|single_hit)
             || (range_en && addr >= range_lo && addr <= range_hi);

endmodule : bct_match

// ### logic/bct_top.sv
/*
  Bus-cycle trace capture unit: watches the observed bus, stores cycles into
  the capture memory, APB register file for set-up and read-back.
  Assumes bus inputs synchronous to ref_clk, one valid strobe per bus cycle,
  and a run signal that is high while the user program executes.
*/
// Function
// - Memory holds 8K entries of 32 bits
// - Aux byte holds test points, mark, rw
// - Execution mode stores every program cycle in its capture window
// - Selective mode stores only chosen cycles
// - Trigger match starts or stops execution capture
// - Selective mode stores cycles matching trigger addresses
// - Execution mode marks instruction first cycles
// - Selective mode marks every stored entry
// - Centered type keeps 4096 before, 4096 after
// - Full memory raises non-maskable interrupt
// - Trigger memory position is recorded
// - Several independent trigger addresses may match
// - Inclusive address range also triggers
// - Armed capture waits for next program run
// - New configuration cancels previous armed one
// - Armed indication readable by host
// - Reset and new configuration empty memory
// - Partial capture stays readable after stop
// - Untriggered centered capture points at last instruction
`include "bct_map.svh"

module bct_top
  import bct_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire bct_cycle_t  bus_cycle,
  input  wire logic        prog_run,
  output logic             nmi_req,
  output logic             capture_armed_indication
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  typedef enum {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} bct_state_t;
  bct_state_t         state_q;
  logic [4*16-1:0]    trig_q;
  logic [15:0]        range_lo_q;
  logic [15:0]        range_hi_q;
  logic               range_en_q;
  bct_mode_t          mode_q;
  bct_type_t          type_q;
  logic [12:0]        wr_ptr_q;
  logic [13:0]        count_q;
  logic [12:0]        post_q;
  logic               triggered_q;
  logic               full_q;
  logic               wrapped_q;
  logic [12:0]        trig_pos_q;
  logic [12:0]        last_ins_q;
  logic [12:0]        rd_addr_q;
  logic               storing_q;
  logic               prog_run_q;
  logic               nmi_q;
  logic               wr_en;
  logic               rd_en;
  logic               cfg_load;
  logic               hit;
  logic               run_start;
  logic               store;
  logic               store_mark;
  bct_entry_t         entry;
  bct_entry_t         mem_rdata;
  logic [12:0]        ref_pos;
  function automatic logic reg_sel(input logic [11:0] a, input logic [11:0] ofs);
    reg_sel = (a == ofs);
  endfunction : reg_sel
  function automatic logic trig_sel(input logic [11:0] a, input int idx);
    trig_sel = (a == (`BCT_OFS_TRIG_BASE + 12'(idx * 4)));
  endfunction : trig_sel
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  // Writing the arm bit loads a fresh configuration
  assign cfg_load = wr_en && reg_sel(paddr, `BCT_OFS_CTRL) && pwdata[`BCT_CTRL_ARM];

  genvar g;
  generate
    for (g = 0; g < `BCT_NUM_TRIG; g++)
    begin : g_trig
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          trig_q[g*16 +: 16] <= `BCT_TRIG_RST;
        else if (wr_en && trig_sel(paddr, g))
          trig_q[g*16 +: 16] <= pwdata[15:0];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      range_lo_q <= `BCT_TRIG_RST;
      range_hi_q <= `BCT_TRIG_RST;
    end
    else if (wr_en && reg_sel(paddr, `BCT_OFS_RANGE_LO))
      range_lo_q <= pwdata[15:0];
    else if (wr_en && reg_sel(paddr, `BCT_OFS_RANGE_HI))
      range_hi_q <= pwdata[15:0];
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      range_en_q <= 1'b0;
      mode_q     <= BCT_MODE_EXEC;
      type_q     <= BCT_TYPE_AFTER;
    end
    else if (cfg_load)
    begin
      range_en_q <= pwdata[`BCT_CTRL_RANGE_EN];
      mode_q     <= bct_mode_t'(pwdata[`BCT_CTRL_MODE_LSB]);
      type_q     <= bct_type_t'(pwdata[`BCT_CTRL_TYPE_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rd_addr_q <= 13'h0000;
    else if (wr_en && reg_sel(paddr, `BCT_OFS_RD_ADDR))
      rd_addr_q <= pwdata[12:0];
  end

  // Memory read data settle one cycle after the read address register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      case (paddr)
        `BCT_OFS_CTRL:     prdata <= {27'h0, type_q, mode_q, range_en_q, 1'b0};
        `BCT_OFS_STATUS:   prdata <= {26'h0, wrapped_q, (count_q == 14'h0000), full_q,
                                      triggered_q, (state_q == ST_RUN),
                                      (state_q == ST_ARMED)};
        `BCT_OFS_TRIG_POS: prdata <= {19'h0, ref_pos};
        `BCT_OFS_WR_PTR:   prdata <= {18'h0, count_q};
        `BCT_OFS_RD_ADDR:  prdata <= {19'h0, rd_addr_q};
        `BCT_OFS_RD_DATA:  prdata <= mem_rdata;
        `BCT_OFS_RANGE_LO: prdata <= {16'h0, range_lo_q};
        `BCT_OFS_RANGE_HI: prdata <= {16'h0, range_hi_q};
        default:
        begin
          prdata <= 32'h0000_0000;
          for (int i = 0; i < `BCT_NUM_TRIG; i++)
          begin
            if (trig_sel(paddr, i))
            begin
              prdata <= {16'h0, trig_q[i*16 +: 16]};
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture control

  bct_match u_match (
    .addr      (bus_cycle.addr),
    .trig_addr (trig_q),
    .range_en  (range_en_q),
    .range_lo  (range_lo_q),
    .range_hi  (range_hi_q),
    .hit       (hit)
  );

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      prog_run_q <= 1'b0;
    else
      prog_run_q <= prog_run;
  end
  assign run_start = prog_run && !prog_run_q;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= ST_IDLE;
    else if (cfg_load)
      state_q <= ST_ARMED;
    else
    begin
      case (state_q)
        ST_IDLE:  state_q <= ST_IDLE;
        ST_ARMED: if (run_start) state_q <= ST_RUN;
        ST_RUN:   if (!prog_run || full_q) state_q <= ST_DONE;
        ST_DONE:  state_q <= ST_DONE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  assign capture_armed_indication = (state_q == ST_ARMED);

  // Decide whether this cycle is stored
  always_comb
  begin
    store      = 1'b0;
    store_mark = 1'b0;
    if (state_q == ST_RUN && bus_cycle.valid && prog_run && !full_q)
    begin
      if (mode_q == BCT_MODE_SELECT)
      begin
        store      = hit;
        store_mark = 1'b1;
      end
      else
      begin
        store_mark = bus_cycle.first;
        case (type_q)
          BCT_TYPE_AFTER:  store = triggered_q || (hit && bus_cycle.first);
          BCT_TYPE_BEFORE: store = !(hit && bus_cycle.first);
          default:         store = 1'b1;
        endcase
      end
    end
  end

  assign entry.addr = bus_cycle.addr;
  assign entry.data = bus_cycle.data;
  assign entry.aux  = {bus_cycle.rw, store_mark, bus_cycle.tp};

  bct_mem u_mem (
    .ref_clk (ref_clk),
    .we      (store),
    .waddr   (wr_ptr_q),
    .wdata   (entry),
    .raddr   (rd_addr_q),
    .rdata   (mem_rdata)
  );

  // Write pointer, fill count and wrap handling
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_q  <= 13'h0000;
      count_q   <= 14'h0000;
      wrapped_q <= 1'b0;
    end
    else if (cfg_load)
    begin
      wr_ptr_q  <= 13'h0000;
      count_q   <= 14'h0000;
      wrapped_q <= 1'b0;
    end
    else if (store)
    begin
      wr_ptr_q <= wr_ptr_q + 13'h0001;
      if (count_q != 14'(`BCT_DEPTH))
      begin
        count_q <= count_q + 14'h0001;
      end
      if (wr_ptr_q == 13'h1FFF)
      begin
        wrapped_q <= 1'b1;
      end
    end
  end

  // Trigger, post-trigger count, full detection
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      triggered_q <= 1'b0;
      post_q      <= 13'h0000;
      full_q      <= 1'b0;
      trig_pos_q  <= 13'h0000;
    end
    else if (cfg_load)
    begin
      triggered_q <= 1'b0;
      post_q      <= 13'h0000;
      full_q      <= 1'b0;
      trig_pos_q  <= 13'h0000;
    end
    else if (state_q == ST_RUN && bus_cycle.valid && prog_run && !full_q
             && mode_q == BCT_MODE_EXEC)
    begin
      if (!triggered_q && hit && bus_cycle.first)
      begin
        triggered_q <= 1'b1;
        trig_pos_q  <= wr_ptr_q;
        if (type_q == BCT_TYPE_BEFORE)
        begin
          full_q <= 1'b1;
        end
      end
      else if (triggered_q && store)
      begin
        post_q <= post_q + 13'h0001;
        // Centered keeps half after trigger, after-type fills whole memory
        if ((type_q == BCT_TYPE_ABOUT && post_q == 13'(`BCT_HALF - 2))
            || (type_q == BCT_TYPE_AFTER && post_q == 13'(`BCT_DEPTH - 2)))
        begin
          full_q <= 1'b1;
        end
      end
    end
    else if (store && wr_ptr_q == 13'h1FFF && mode_q == BCT_MODE_SELECT)
    begin
      full_q <= 1'b1;
    end
  end

  // Last instruction start, used when the centered capture never triggers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      last_ins_q <= 13'h0000;
    else if (cfg_load)
      last_ins_q <= 13'h0000;
    else if (store && store_mark)
      last_ins_q <= wr_ptr_q;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      nmi_q <= 1'b0;
    else if (cfg_load)
      nmi_q <= 1'b0;
    else if (state_q == ST_RUN && full_q)
      nmi_q <= 1'b1;
    else if (!prog_run)
      nmi_q <= 1'b0;
  end

  assign nmi_req = nmi_q;

  // An untriggered centered capture reports its last instruction start
  assign ref_pos = (type_q == BCT_TYPE_ABOUT && !triggered_q) ? last_ins_q
                                                              : trig_pos_q;

endmodule : bct_top

// ### bench/bct_monitor.sv
/*
  Checker of the bus-cycle trace capture unit, bound to bct_top.
  Assumes one clock domain and an APB master that keeps the bus rules.
*/
`include "bct_map.svh"

module bct_monitor
  import bct_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire bct_cycle_t  bus_cycle,
  input wire logic        prog_run,
  input wire logic        nmi_req,
  input wire logic        capture_armed_indication
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  wire logic wr_acc = psel && penable && pwrite;

  ////////////////////////////////////////////////////////////////
  AST_READY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_NO_ERR: assert property (psel && penable |-> !pslverr)
    else $error("pslverr raised");
  AST_ARM_SET: assert property (
    wr_acc && paddr == `BCT_OFS_CTRL && pwdata[0] && !prog_run |=> capture_armed_indication)
    else $error("arm write did not arm");
  AST_ARM_WAIT: assert property (
    capture_armed_indication && !prog_run && !wr_acc |=> capture_armed_indication)
    else $error("armed state lost before run");
  AST_ARM_GO: assert property (
    capture_armed_indication && $rose(prog_run) |-> ##[1:2] !capture_armed_indication)
    else $error("armed state kept after run start");
  AST_NMI_RUN: assert property ($rose(nmi_req) |-> $past(prog_run))
    else $error("nmi raised outside a run");
  AST_NMI_HOLD: assert property (nmi_req && prog_run && !wr_acc |=> nmi_req)
    else $error("nmi dropped during run");
  AST_NMI_DROP: assert property ($fell(prog_run) |-> ##[0:2] !nmi_req)
    else $error("nmi kept after run end");
  AST_RD_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");

  cover property (capture_armed_indication ##1 !capture_armed_indication);
  cover property ($rose(nmi_req));
  cover property (wr_acc && paddr == `BCT_OFS_CTRL);
endmodule : bct_monitor

bind bct_top bct_monitor i_mon (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_cycle(bus_cycle), .prog_run(prog_run),
  .nmi_req(nmi_req), .capture_armed_indication(capture_armed_indication));

// ### bench/bct_bus_model.sv
/*
  Model of the observed processor bus: program run level and bus cycles.
  Assumes the bench calls its tasks; idle cycles show changing junk.
*/
module bct_bus_model
  import bct_pkg::*;
(
  input  wire logic  ref_clk,
  output bct_cycle_t bus_cycle,
  output logic       prog_run
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    bus_cycle = '0;
    prog_run  = 1'h0;
  end

  task automatic run(input logic on);
    @(posedge ref_clk);
    prog_run <= on;
  endtask : run

  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rw,
                     input logic f, input logic [5:0] tp);
    @(posedge ref_clk);
    bus_cycle <= '{1'h1, a, d, rw, f, tp};
  endtask : cyc

  // Released bus shows the inverse of the last value
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      bus_cycle <= {1'h0, ~bus_cycle[31:0]};
    end
  endtask : idle
endmodule : bct_bus_model

// ### bench/bct_top_tb.sv
/*
  Self-checking bench of the trace capture unit.
  Assumes the APB slave, bus model and checker sit beside it.
*/
`include "bct_map.svh"

module bct_top_tb
  import bct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, prog_run;
  logic        nmi_req, armed;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  bct_cycle_t  bus_cycle;
  int          fails, checked;

  bct_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_cycle(bus_cycle), .prog_run(prog_run), .nmi_req(nmi_req),
    .capture_armed_indication(armed));
  bct_bus_model i_bus (.ref_clk(ref_clk), .bus_cycle(bus_cycle), .prog_run(prog_run));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    r = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 16)
    begin
      fails++;
      finish_test();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(r, x);
  endtask : rdc

  task automatic ent(input logic [12:0] i, input logic [31:0] x);
    wr(`BCT_OFS_RD_ADDR, {19'h0, i});
    repeat (2) @(posedge ref_clk);
    rdc(`BCT_OFS_RD_DATA, x);
  endtask : ent

  task automatic stop();
    i_bus.idle(3);
    i_bus.run(1'h0);
    i_bus.idle(2);
  endtask : stop

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(`BCT_OFS_STATUS, 32'h10);
    rdc(`BCT_OFS_TRIG_BASE, 32'hFFFF);
    rdc(`BCT_OFS_WR_PTR, 32'h0);
    rdc(12'h0FC, 32'h0);
    chk(armed, 32'h0);
  endtask : t_reset

  task automatic t_after();
    wr(`BCT_OFS_TRIG_BASE, 32'hE0A0);
    wr(`BCT_OFS_CTRL, 32'h5);
    wr(`BCT_OFS_CTRL, 32'h1);
    i_bus.idle(2);
    chk(armed, 32'h1);
    i_bus.run(1'h1);
    i_bus.cyc(16'hD010, 8'h11, 1'h1, 1'h1, 6'h01);
    i_bus.cyc(16'hE0A0, 8'h86, 1'h1, 1'h1, 6'h2A);
    i_bus.cyc(16'hE0A1, 8'h10, 1'h1, 1'h0, 6'h15);
    i_bus.cyc(16'h1020, 8'h55, 1'h0, 1'h1, 6'h3F);
    stop();
    rdc(`BCT_OFS_WR_PTR, 32'h3);
    rdc(`BCT_OFS_TRIG_POS, 32'h0);
    ent(13'h0, 32'hE0A086EA);
    ent(13'h1, 32'hE0A11095);
    ent(13'h2, 32'h1020557F);
  endtask : t_after

  task automatic t_select();
    wr(`BCT_OFS_TRIG_BASE + 12'h4, 32'hD000);
    wr(`BCT_OFS_RANGE_LO, 32'hE106);
    wr(`BCT_OFS_RANGE_HI, 32'hE112);
    wr(`BCT_OFS_CTRL, 32'h7);
    i_bus.run(1'h1);
    i_bus.cyc(16'hE105, 8'hA0, 1'h1, 1'h1, 6'h00);
    i_bus.cyc(16'hE106, 8'hA1, 1'h1, 1'h0, 6'h01);
    i_bus.cyc(16'hE112, 8'hA2, 1'h0, 1'h0, 6'h02);
    i_bus.cyc(16'hE113, 8'hA5, 1'h1, 1'h0, 6'h00);
    i_bus.idle(2);
    i_bus.cyc(16'hD000, 8'hA3, 1'h1, 1'h0, 6'h03);
    i_bus.cyc(16'hE0A0, 8'hA4, 1'h0, 1'h1, 6'h04);
    i_bus.cyc(16'hF000, 8'hA6, 1'h1, 1'h1, 6'h00);
    stop();
    rdc(`BCT_OFS_WR_PTR, 32'h4);
    ent(13'h0, 32'hE106A1C1);
    ent(13'h1, 32'hE112A242);
    ent(13'h2, 32'hD000A3C3);
    ent(13'h3, 32'hE0A0A444);
  endtask : t_select

  task automatic t_full();
    int n;
    wr(`BCT_OFS_CTRL, 32'h1);
    i_bus.run(1'h1);
    i_bus.cyc(16'hE0A0, 8'h01, 1'h1, 1'h1, 6'h00);
    for (n = 1; n < 8191; n++)
      i_bus.cyc(16'h2000 + n[15:0], n[7:0], 1'h1, 1'h0, 6'h00);
    chk(nmi_req, 32'h0);
    i_bus.cyc(16'h0100, 8'hFF, 1'h0, 1'h0, 6'h00);
    n = 0;
    while (nmi_req !== 1'h1 && n < 8)
    begin
      i_bus.idle(1);
      n++;
    end
    chk(nmi_req, 32'h1);
    if (n >= 8)
      finish_test();
    stop();
    chk(nmi_req, 32'h0);
    rdc(`BCT_OFS_STATUS, 32'h2C);
    wr(`BCT_OFS_CTRL, 32'h1);
    rdc(`BCT_OFS_WR_PTR, 32'h0);
    rdc(`BCT_OFS_STATUS, 32'h11);
  endtask : t_full

  task automatic t_about();
    int n;
    wr(`BCT_OFS_CTRL, 32'h11);
    i_bus.run(1'h1);
    for (n = 0; n < 5; n++)
      i_bus.cyc(16'h3000 + n[15:0], 8'h40, 1'h1, 1'h1, 6'h00);
    stop();
    rdc(`BCT_OFS_WR_PTR, 32'h5);
    rdc(`BCT_OFS_TRIG_POS, 32'h4);
    ent(13'h4, 32'h300440C0);
  endtask : t_about

  task automatic t_before();
    wr(`BCT_OFS_CTRL, 32'h9);
    i_bus.run(1'h1);
    i_bus.cyc(16'h3000, 8'h21, 1'h1, 1'h1, 6'h00);
    i_bus.cyc(16'h3001, 8'h22, 1'h1, 1'h0, 6'h00);
    i_bus.cyc(16'hE0A0, 8'h23, 1'h1, 1'h1, 6'h00);
    i_bus.idle(3);
    chk(nmi_req, 32'h1);
    stop();
    chk(nmi_req, 32'h0);
    rdc(`BCT_OFS_WR_PTR, 32'h2);
    rdc(`BCT_OFS_TRIG_POS, 32'h2);
    ent(13'h1, 32'h30012280);
  endtask : t_before

  task automatic t_rst();
    wr(`BCT_OFS_CTRL, 32'h11);
    i_bus.run(1'h1);
    i_bus.cyc(16'h3100, 8'h31, 1'h1, 1'h1, 6'h00);
    i_bus.idle(1);
    nrst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    stop();
    rdc(`BCT_OFS_WR_PTR, 32'h0);
    rdc(`BCT_OFS_STATUS, 32'h10);
    chk(armed, 32'h0);
  endtask : t_rst

  ////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    nrst    = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    t_reset();
    t_after();
    t_select();
    t_full();
    t_about();
    t_before();
    t_rst();
    finish_test();
  end
endmodule : bct_top_tb
